// *** rtl/tcvr_flag_pkg.sv ***
package tcvr_flag_pkg;

   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned T_UV_FILTER_MS = 100;
   localparam int unsigned T_TX_DOM_TIMEOUT_NS = 1_200_000;
   localparam int unsigned T_BUS_DOM_TIMEOUT_NS = 1_200_000;
   localparam int unsigned T_EDGE_SPACING_NS = 4_000;
   localparam int unsigned T_FAULT_CLEAR_NS = 4_000;
   // Least times round up to whole cycles
   localparam int unsigned UV_FILTER_CYCLES =
      (T_UV_FILTER_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TX_DOM_TIMEOUT_CYCLES =
      (T_TX_DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BUS_DOM_TIMEOUT_CYCLES =
      (T_BUS_DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EDGE_SPACING_CYCLES =
      (T_EDGE_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FAULT_CLEAR_CYCLES =
      (T_FAULT_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 24;

   // ****************************************
   // Counts and reset values
   // ****************************************
   localparam logic [2:0] SRC_CLEAR_EDGES = 3'h4;
   localparam logic [2:0] EDGE_CNT_RESET = 3'h0;

   // ****************************************
   // Operating modes, set by the mode controller
   // ****************************************
   typedef enum logic [2:0] {
      MODE_OFF = 3'h0,
      MODE_SLEEP = 3'h1,
      MODE_GOTOSLEEP = 3'h3,
      MODE_STANDBY = 3'h2,
      MODE_SILENT = 3'h6,
      MODE_NORMAL = 3'h7
   } mode_e;

   // Pin levels entering from outside the clock domain
   typedef struct packed {
      logic tx;
      logic rx_sense;
      logic bus_dom;
      logic wake;
      logic battery_ok;
      logic core_ok;
      logic io_ok;
   } pins_s;

   // Status flags
   typedef struct packed {
      logic cold_start_flag;
      logic wake_request_flag;
      logic wake_source_flag;
      logic wake_source_local;
      logic core_supply_low_flag;
      logic io_supply_low_flag;
      logic battery_low_flag;
      logic tx_dominant_timeout_flag;
      logic tx_rx_short_flag;
      logic bus_stuck_dominant_flag;
   } flags_s;

   localparam pins_s PINS_RESET = 7'h40;
   localparam flags_s FLAGS_RESET = 10'h000;

endpackage

// *** rtl/hold_timer.sv ***
`timescale 1ns/10ps
module hold_timer
   import tcvr_flag_pkg::*;
#(
   parameter int unsigned LIMIT = 1
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Control
   input wire logic restart_i,
   input wire logic hold_i,
   // Status
   output logic expired_o
);

   localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   // Count while the condition holds, saturate at the limit
   assign cnt_d = (restart_i || !hold_i) ? '0 :
                  (cnt_q == LIMIT_C) ? cnt_q : cnt_q + 1'b1;
   assign expired_o = (cnt_q == LIMIT_C);

   // Counter register
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   chk_timer_hold_drop: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !hold_i |=> !expired_o) else $error("timer expired without hold");
   chk_timer_reach_limit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (hold_i && !restart_i && cnt_q == LIMIT_C - 1'b1) |=> expired_o)
      else $error("timer missed its limit");

endmodule

// *** rtl/transceiver_status_flag_logic.sv ***
// Function
// - Receive output goes low on power-on or wake-up event.
// - Fault indicator held high in sleep mode.
// - Inhibit driven in every mode except sleep, released in sleep.
// - Local wake recognised on rising or falling wake edge.
// - Faults ORed onto fault indicator; receive output shows wake request.
// - Cold start set on battery rise, reported entering silent from standby/sleep.
// - Cold start cleared only by transition into normal mode.
// - Cold start sets wake request, cold start and local wake source.
// - Wake request set in standby, go-to-sleep or sleep, or by a cold start in any mode.
// - Setting wake request restarts core and I/O undervoltage timers.
// - Wake request cleared entering normal or on filtered supply undervoltage.
// - After wake, standby drives fault indicator and receive output low.
// - Go-to-sleep blocked while wake request is set.
// - In normal, fault low for local source, high for bus; first kept.
// - Source flag cleared by four spaced tx edges, leaving normal, undervoltage.
// - Supply flags internal; core and I/O clear on recovery or wake.
// - Core and I/O flags set only after the filter time.
// - Tx dominant timeout disables driver, reported entering silent from normal.
// - Timeout cleared by tx high, rx low for 4us, or entry into any mode but silent or off.
// - Tx/rx short set after both low for dominant timeout; driver off.
// - Short cleared on tx recessive edge with rx low, or entry into any mode but silent or off.
// - Bus stuck dominant set after timeout, cleared on rx recessive edge.
// - Undervoltage filter time lies between 100 and 350 ms.
`timescale 1ns/10ps
module transceiver_status_flag_logic
   import tcvr_flag_pkg::*;
#(
   parameter int unsigned UV_FILTER_CYCLES_P = UV_FILTER_CYCLES,
   parameter int unsigned TX_DOM_TIMEOUT_CYCLES_P = TX_DOM_TIMEOUT_CYCLES,
   parameter int unsigned BUS_DOM_TIMEOUT_CYCLES_P = BUS_DOM_TIMEOUT_CYCLES
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Pin levels and supply comparators
   input wire pins_s pins_i,
   // Mode and remote wake from on-chip logic
   input wire mode_e mode_i,
   input wire logic remote_wake_i,
   // Controller-facing indications
   output logic fault_indicator_n_o,
   output logic rx_data_o,
   // Regulator inhibit pin
   output logic regulator_inhibit_out_o,
   output logic regulator_inhibit_oe_o,
   // Driver and mode controller
   output logic driver_enable_o,
   output logic go_to_sleep_block_o,
   output flags_s flags_o
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   pins_s sync1_q;
   pins_s s;

   // Two flops before any logic looks at a pin
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync1_q <= PINS_RESET;
         s <= PINS_RESET;
      end
      else
      begin
         sync1_q <= pins_i;
         s <= sync1_q;
      end
   end

   // Previous levels for edge detection
   pins_s prev_q;
   mode_e mode_q;

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         prev_q <= PINS_RESET;
         mode_q <= MODE_OFF;
      end
      else
      begin
         prev_q <= s;
         mode_q <= mode_i;
      end
   end

   // ****************************************
   // Mode decode
   // ****************************************
   logic mode_change;
   logic enter_normal;
   logic leave_normal;
   logic in_normal;
   logic active_mode;
   logic wake_mode;
   logic enter_silent_nrm;
   logic enter_silent_low;
   logic local_clear;

   // Mode transitions that steer flag clearing and reporting
   assign mode_change = (mode_i != mode_q);
   assign in_normal = (mode_i == MODE_NORMAL);
   assign enter_normal = mode_change && in_normal;
   assign leave_normal = mode_change && (mode_q == MODE_NORMAL);
   assign active_mode = in_normal || (mode_i == MODE_SILENT);
   assign wake_mode = (mode_i == MODE_STANDBY) || (mode_i == MODE_GOTOSLEEP)
                      || (mode_i == MODE_SLEEP);
   assign enter_silent_nrm = mode_change && (mode_i == MODE_SILENT)
                             && (mode_q == MODE_NORMAL);
   assign enter_silent_low = mode_change && (mode_i == MODE_SILENT)
                             && ((mode_q == MODE_STANDBY) || (mode_q == MODE_SLEEP));
   assign local_clear = mode_change && (mode_i != MODE_SILENT) && (mode_i != MODE_OFF);

   // ****************************************
   // Edge events
   // ****************************************
   logic cold_evt;
   logic lwu_evt;
   logic tx_to_dom;
   logic tx_to_rec;
   logic bus_to_rec;
   logic wake_set;

   // Battery rise is a cold start
   assign cold_evt = s.battery_ok && !prev_q.battery_ok;
   // Either wake pin edge is a local wake
   assign lwu_evt = s.wake ^ prev_q.wake;
   assign tx_to_dom = !s.tx && prev_q.tx;
   assign tx_to_rec = s.tx && !prev_q.tx;
   assign bus_to_rec = !s.bus_dom && prev_q.bus_dom;
   // Wake request sources, gated by mode except for a cold start
   assign wake_set = cold_evt || (wake_mode && (lwu_evt || remote_wake_i));

   // ****************************************
   // Filter timers
   // ****************************************
   logic core_exp;
   logic io_exp;
   logic dto_exp;
   logic short_exp;
   logic busdom_exp;
   logic fclr_exp;
   logic spacing_ok;
   logic uv_evt;

   // Core supply undervoltage filter, restarted by a wake request
   hold_timer #(.LIMIT(UV_FILTER_CYCLES_P)) u_core_timer (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .restart_i(wake_set),
      .hold_i(!s.core_ok),
      .expired_o(core_exp)
   );

   // I/O supply undervoltage filter
   hold_timer #(.LIMIT(UV_FILTER_CYCLES_P)) u_io_timer (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .restart_i(wake_set),
      .hold_i(!s.io_ok),
      .expired_o(io_exp)
   );

   // Transmit held dominant
   hold_timer #(.LIMIT(TX_DOM_TIMEOUT_CYCLES_P)) u_dto_timer (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .restart_i(1'b0),
      .hold_i(!s.tx && active_mode),
      .expired_o(dto_exp)
   );

   // Transmit and receive lines both low
   hold_timer #(.LIMIT(TX_DOM_TIMEOUT_CYCLES_P)) u_short_timer (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .restart_i(1'b0),
      .hold_i(!s.tx && !s.rx_sense && active_mode),
      .expired_o(short_exp)
   );

   // Bus held dominant
   hold_timer #(.LIMIT(BUS_DOM_TIMEOUT_CYCLES_P)) u_busdom_timer (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .restart_i(1'b0),
      .hold_i(s.bus_dom && active_mode),
      .expired_o(busdom_exp)
   );

   // Transmit high with bus dominant in normal mode
   hold_timer #(.LIMIT(FAULT_CLEAR_CYCLES)) u_fclr_timer (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .restart_i(1'b0),
      .hold_i(s.tx && s.bus_dom && in_normal),
      .expired_o(fclr_exp)
   );

   // Time since the last dominant edge on transmit
   hold_timer #(.LIMIT(EDGE_SPACING_CYCLES)) u_spacing_timer (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .restart_i(tx_to_dom),
      .hold_i(1'b1),
      .expired_o(spacing_ok)
   );

   assign uv_evt = core_exp || io_exp;

   // ****************************************
   // Wake source clearing edge count
   // ****************************************
   logic [2:0] edge_cnt_q;
   logic [2:0] edge_cnt_d;
   logic edge_counts;
   logic src_clear_edges;

   // The first edge always counts, later ones only if spaced far enough apart
   assign edge_counts = in_normal && tx_to_dom && flags_o.wake_source_flag
                        && ((edge_cnt_q == EDGE_CNT_RESET) || spacing_ok);
   assign src_clear_edges = edge_counts && (edge_cnt_q == SRC_CLEAR_EDGES - 3'h1);
   assign edge_cnt_d = (!in_normal || !flags_o.wake_source_flag || src_clear_edges)
                       ? EDGE_CNT_RESET
                       : edge_counts ? edge_cnt_q + 3'h1 : edge_cnt_q;

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         edge_cnt_q <= EDGE_CNT_RESET;
      end
      else
      begin
         edge_cnt_q <= edge_cnt_d;
      end
   end

   // ****************************************
   // Flag next values, set wins over clear
   // ****************************************
   flags_s flags_d;
   flags_s f;
   logic src_capture;

   assign f = flags_o;
   assign src_capture = wake_set && !f.wake_source_flag;

   assign flags_d.cold_start_flag = cold_evt || (f.cold_start_flag && !enter_normal);
   assign flags_d.wake_request_flag = wake_set
                                      || (f.wake_request_flag && !enter_normal && !uv_evt);
   assign flags_d.wake_source_flag = wake_set
                                     || (f.wake_source_flag && !src_clear_edges
                                         && !leave_normal && !uv_evt);
   // First source is kept while the flag stays set
   assign flags_d.wake_source_local = src_capture ? (cold_evt || lwu_evt)
                                      : f.wake_source_local;
   assign flags_d.core_supply_low_flag = core_exp
                                         || (f.core_supply_low_flag && !s.core_ok
                                             && !wake_set);
   assign flags_d.io_supply_low_flag = io_exp
                                       || (f.io_supply_low_flag && !s.io_ok
                                           && !wake_set);
   assign flags_d.battery_low_flag = !s.battery_ok;
   assign flags_d.tx_dominant_timeout_flag = dto_exp
                                             || (f.tx_dominant_timeout_flag
                                                 && !fclr_exp && !local_clear);
   // Timer set terms need their condition still present, else the clearing edge is lost
   assign flags_d.tx_rx_short_flag = (short_exp && !s.tx && !s.rx_sense)
                                     || (f.tx_rx_short_flag && !local_clear
                                         && !(tx_to_rec && !s.rx_sense));
   assign flags_d.bus_stuck_dominant_flag = (busdom_exp && s.bus_dom)
                                            || (f.bus_stuck_dominant_flag && !bus_to_rec
                                                && !local_clear);

   // Flag register
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         flags_o <= FLAGS_RESET;
      end
      else
      begin
         flags_o <= flags_d;
      end
   end

   // ****************************************
   // Reporting windows
   // ****************************************
   logic report_local_q;
   logic report_cold_q;
   logic report_local_d;
   logic report_cold_d;

   // Local faults show only after normal to silent, cold start after standby/sleep
   assign report_local_d = enter_silent_nrm || (report_local_q && !mode_change);
   assign report_cold_d = enter_silent_low || (report_cold_q && !mode_change);

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         report_local_q <= 1'b0;
         report_cold_q <= 1'b0;
      end
      else
      begin
         report_local_q <= report_local_d;
         report_cold_q <= report_cold_d;
      end
   end

   // ****************************************
   // Output decode
   // ****************************************
   logic local_any;
   logic fault_any;
   logic rx_d;
   logic drv_en_d;
   logic inh_oe_d;

   assign local_any = f.tx_dominant_timeout_flag || f.tx_rx_short_flag
                      || f.bus_stuck_dominant_flag;
   // All reported conditions ORed, nothing reported in sleep
   assign fault_any =
      ((mode_i == MODE_STANDBY) && f.wake_request_flag)
      || ((mode_i == MODE_SILENT) && ((report_local_q && local_any)
                                     || (report_cold_q && f.cold_start_flag)))
      || (in_normal && f.wake_source_flag && f.wake_source_local);
   // Bus mirror when active, otherwise low on a pending wake
   assign rx_d = active_mode ? !s.bus_dom : !f.wake_request_flag;
   assign drv_en_d = in_normal && !f.tx_dominant_timeout_flag
                     && !f.tx_rx_short_flag;
   assign inh_oe_d = (mode_i != MODE_SLEEP);

   // Output register
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         fault_indicator_n_o <= 1'b1;
         rx_data_o <= 1'b1;
         regulator_inhibit_out_o <= 1'b1;
         regulator_inhibit_oe_o <= 1'b0;
         driver_enable_o <= 1'b0;
         go_to_sleep_block_o <= 1'b0;
      end
      else
      begin
         fault_indicator_n_o <= !fault_any;
         rx_data_o <= rx_d;
         regulator_inhibit_out_o <= 1'b1;
         regulator_inhibit_oe_o <= inh_oe_d;
         driver_enable_o <= drv_en_d;
         go_to_sleep_block_o <= f.wake_request_flag;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence seq_silent_from_normal;
      enter_silent_nrm ##1 (local_any && mode_i == MODE_SILENT);
   endsequence

   chk_inh_sleep_release: assert property (
      (mode_i == MODE_SLEEP) |=> !regulator_inhibit_oe_o ##0 regulator_inhibit_out_o)
      else $error("inhibit driven in sleep");
   chk_inh_awake_drive: assert property (
      (mode_i != MODE_SLEEP) |=> regulator_inhibit_oe_o)
      else $error("inhibit released outside sleep");
   chk_sleep_fault_high: assert property (
      (mode_i == MODE_SLEEP) |=> fault_indicator_n_o)
      else $error("fault reported in sleep");
   chk_wake_rx_low: assert property (
      (f.wake_request_flag && !active_mode) |=> !rx_data_o)
      else $error("receive output not low on wake");
   chk_standby_report: assert property (
      (f.wake_request_flag && mode_i == MODE_STANDBY) |=> !fault_indicator_n_o && !rx_data_o)
      else $error("standby wake not reported");
   chk_lwu_wake_set: assert property (
      (wake_mode && (s.wake != prev_q.wake)) |=> f.wake_request_flag)
      else $error("local wake edge missed");
   chk_cold_start_set: assert property (
      cold_evt |=> f.cold_start_flag && f.wake_request_flag
                   && f.wake_source_flag && f.wake_source_local)
      else $error("cold start flags incomplete");
   chk_cold_normal_clr: assert property (
      (enter_normal && !cold_evt) |=> !f.cold_start_flag)
      else $error("cold start not cleared in normal");
   chk_wake_mode_only: assert property (
      (!wake_mode && !cold_evt && !f.wake_request_flag) |=> !f.wake_request_flag)
      else $error("wake request set outside wake modes");
   chk_sleep_blocked: assert property (
      f.wake_request_flag |=> go_to_sleep_block_o)
      else $error("go-to-sleep not blocked");
   chk_source_kept: assert property (
      (f.wake_source_flag && flags_d.wake_source_flag) |=> $stable(f.wake_source_local))
      else $error("wake source overwritten");
   chk_local_report: assert property (
      seq_silent_from_normal |=> !fault_indicator_n_o)
      else $error("local fault not reported in silent");
   chk_dto_driver_off: assert property (
      f.tx_dominant_timeout_flag |=> !driver_enable_o)
      else $error("driver enabled during timeout");
   chk_short_clear: assert property (
      (f.tx_rx_short_flag && local_clear && !short_exp) |=> !f.tx_rx_short_flag)
      else $error("short flag not cleared");
   chk_busdom_clear: assert property (
      bus_to_rec |=> !f.bus_stuck_dominant_flag)
      else $error("bus dominant flag not cleared");
   chk_short_tx_clear: assert property (
      (tx_to_rec && !s.rx_sense) |=> !f.tx_rx_short_flag)
      else $error("short flag kept after tx release");
   chk_source_leave: assert property (
      (leave_normal && !wake_set) |=> !f.wake_source_flag)
      else $error("source flag kept after leaving normal");

endmodule

// *** dv/can_ctrl_model.sv ***
`timescale 1ns/10ps
// ****************************************
// Controller transmit model
// ****************************************
module can_ctrl_model
#(
   parameter int unsigned GAP = 600
)
(
   // Clock
   input wire logic ref_clk_i,
   // Commands from the bench
   input wire logic start_i,
   input wire logic hold_dom_i,
   // Transmit line and status
   output logic tx_o,
   output logic busy_o
);
   logic tx_q = 1'b1;
   logic busy_q = 1'b0;

   // Four dominant pulses; edges spaced past the minimum
   always @(posedge ref_clk_i)
   begin
      if (start_i && !busy_q)
      begin
         busy_q = 1'b1;
         repeat (4)
         begin
            @(negedge ref_clk_i) tx_q = 1'b0;
            repeat (50) @(negedge ref_clk_i);
            tx_q = 1'b1;
            repeat (GAP) @(negedge ref_clk_i);
         end
         busy_q = 1'b0;
      end
   end

   // Held dominant on command, otherwise follows the pulse level
   assign tx_o = tx_q & ~hold_dom_i;
   assign busy_o = busy_q;
endmodule

// *** dv/transceiver_status_flag_logic_test.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, 10'(e), 10'(g))
// ****************************************
// Status flag bench
// ****************************************
module transceiver_status_flag_logic_test
   import tcvr_flag_pkg::*;
;
   localparam int unsigned UVC = 200;
   localparam int unsigned TXC = 100;
   localparam int unsigned BUSC = 100;
   logic ref_clk;
   logic reset;
   pins_s pins;
   pins_s pins_in;
   mode_e mode;
   logic remote_wake;
   logic start;
   logic hold_dom;
   logic tx;
   logic busy;
   logic fault_n;
   logic rx_data;
   logic inh_oe;
   logic inh_out;
   logic drv_en;
   logic block;
   flags_s flags;
   int failures = 0;
   int comparisons = 0;
   int seed = 32'hbbcd0d1b;
   int i;

   // Clock
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Transmit line comes from the controller model
   always_comb
   begin
      pins_in = pins;
      pins_in.tx = tx;
   end

   can_ctrl_model u_can_ctrl_model (.ref_clk_i(ref_clk), .start_i(start),
      .hold_dom_i(hold_dom), .tx_o(tx), .busy_o(busy));

   transceiver_status_flag_logic #(.UV_FILTER_CYCLES_P(UVC),
      .TX_DOM_TIMEOUT_CYCLES_P(TXC), .BUS_DOM_TIMEOUT_CYCLES_P(BUSC))
   u_transceiver_status_flag_logic (.ref_clk_i(ref_clk), .reset_i(reset),
      .pins_i(pins_in), .mode_i(mode), .remote_wake_i(remote_wake),
      .fault_indicator_n_o(fault_n), .rx_data_o(rx_data),
      .regulator_inhibit_out_o(inh_out), .regulator_inhibit_oe_o(inh_oe),
      .driver_enable_o(drv_en), .go_to_sleep_block_o(block), .flags_o(flags));

   // Helpers
   function automatic flags_s wake_flags(input logic local_src, input logic cold);
      flags_s f;
      f = FLAGS_RESET;
      f.cold_start_flag = cold;
      f.wake_request_flag = 1'b1;
      f.wake_source_flag = 1'b1;
      f.wake_source_local = local_src;
      return f;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic go(input mode_e m);
      mode = m;
      cyc(4);
   endtask

   task automatic check(input string n, input logic [9:0] e, input logic [9:0] g);
      comparisons++;
      if (e !== g)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      #500000;
      failures++;
      complete_run;
   end

   // Main sequence
   initial
   begin
      reset = 1'b1;
      pins = 7'h67;
      mode = MODE_STANDBY;
      remote_wake = 1'b0;
      start = 1'b0;
      hold_dom = 1'b0;
      cyc(12);
      reset = 1'b0;
      cyc(8);
      `CHK("flags", wake_flags(1'b1, 1'b1), flags);
      `CHK("rx_data", 1'b0, rx_data);
      `CHK("fault_n", 1'b0, fault_n);
      `CHK("block", 1'b1, block);
      `CHK("inh_oe", 1'b1, inh_oe);
      `CHK("inh_out", 1'b1, inh_out);
      go(MODE_SILENT);
      `CHK("fault_n", 1'b0, fault_n);
      go(MODE_NORMAL);
      `CHK("cold", 1'b0, flags.cold_start_flag);
      `CHK("wake_req", 1'b0, flags.wake_request_flag);
      `CHK("fault_n", 1'b0, fault_n);
      $display("test cold start done");
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      for (i = 0; i < 4000 && busy; i++)
         cyc(1);
      if (busy)
      begin
         failures++;
         complete_run;
      end
      cyc(4);
      `CHK("wake_src", 1'b0, flags.wake_source_flag);
      `CHK("fault_n", 1'b1, fault_n);
      $display("test source clear done");
      hold_dom = 1'b1;
      cyc(TXC + 10);
      `CHK("dto", 1'b1, flags.tx_dominant_timeout_flag);
      `CHK("drv_en", 1'b0, drv_en);
      hold_dom = 1'b0;
      go(MODE_SILENT);
      `CHK("fault_n", 1'b0, fault_n);
      go(MODE_NORMAL);
      `CHK("dto", 1'b0, flags.tx_dominant_timeout_flag);
      pins.rx_sense = 1'b0;
      hold_dom = 1'b1;
      cyc(TXC + 10);
      `CHK("short", 1'b1, flags.tx_rx_short_flag);
      `CHK("drv_en", 1'b0, drv_en);
      hold_dom = 1'b0;
      cyc(4);
      `CHK("short", 1'b0, flags.tx_rx_short_flag);
      pins.rx_sense = 1'b1;
      go(MODE_STANDBY);
      go(MODE_NORMAL);
      pins.bus_dom = 1'b1;
      cyc(BUSC + 10);
      `CHK("stuck", 1'b1, flags.bus_stuck_dominant_flag);
      `CHK("drv_en", 1'b1, drv_en);
      pins.bus_dom = 1'b0;
      cyc(4);
      `CHK("stuck", 1'b0, flags.bus_stuck_dominant_flag);
      hold_dom = 1'b1;
      cyc(TXC + 10);
      `CHK("dto", 1'b1, flags.tx_dominant_timeout_flag);
      hold_dom = 1'b0;
      pins.bus_dom = 1'b1;
      cyc(FAULT_CLEAR_CYCLES + 10);
      `CHK("dto", 1'b0, flags.tx_dominant_timeout_flag);
      pins.bus_dom = 1'b0;
      cyc(4);
      $display("test local faults done");
      for (i = 0; i < 2; i++)
      begin
         go(i ? MODE_GOTOSLEEP : MODE_SLEEP);
         `CHK("inh_oe", i, inh_oe);
         `CHK("fault_n", 1'b1, fault_n);
         pins.wake = ~pins.wake;
         cyc(6);
         `CHK("wake_req", 1'b1, flags.wake_request_flag);
         go(MODE_STANDBY);
         `CHK("fault_rx", 2'b00, {fault_n, rx_data});
         go(MODE_NORMAL);
         `CHK("fault_n", 1'b0, fault_n);
      end
      go(MODE_STANDBY);
      remote_wake = 1'b1;
      cyc(1);
      remote_wake = 1'b0;
      cyc(4);
      pins.wake = ~pins.wake;
      cyc(4);
      `CHK("wake_req", 1'b1, flags.wake_request_flag);
      go(MODE_NORMAL);
      `CHK("fault_n", 1'b1, fault_n);
      $display("test wake done");
      for (i = 0; i < 40; i++)
      begin
         pins.wake = 1'($random(seed));
         remote_wake = 1'($random(seed));
         cyc(1 + ($random(seed) & 7));
      end
      remote_wake = 1'b0;
      cyc(4);
      `CHK("wake_req", 1'b0, flags.wake_request_flag);
      $display("test random normal done");
      go(MODE_STANDBY);
      pins.wake = ~pins.wake;
      cyc(6);
      {pins.core_ok, pins.io_ok} = 2'b00;
      cyc(UVC / 2);
      `CHK("uv_low", 2'b00, {flags.core_supply_low_flag, flags.io_supply_low_flag});
      cyc(UVC / 2 + 10);
      `CHK("uv_low", 2'b11, {flags.core_supply_low_flag, flags.io_supply_low_flag});
      `CHK("wake_req", 1'b0, flags.wake_request_flag);
      `CHK("fault_n", 1'b1, fault_n);
      {pins.core_ok, pins.io_ok} = 2'b11;
      cyc(6);
      `CHK("uv_low", 2'b00, {flags.core_supply_low_flag, flags.io_supply_low_flag});
      pins.battery_ok = 1'b0;
      cyc(6);
      `CHK("bat_low", 1'b1, flags.battery_low_flag);
      `CHK("fault_n", 1'b1, fault_n);
      pins.battery_ok = 1'b1;
      cyc(6);
      `CHK("cold", 1'b1, flags.cold_start_flag);
      $display("test supply done");
      complete_run;
   end
endmodule
